//--- core/bbf_pkg.sv
// Purpose: shared constants and types for the branch, bit and flag unit
// Assumes: 8-bit data path, status register laid out with carry in bit 0
// Notes: operation codes are produced by the core's instruction decoder

package bbf_pkg;

    // data path and operand widths
    localparam int DATA_W = 8;
    localparam int CORE_STATUS_REGISTER_W = 8;
    localparam int OFF_W = 7;
    localparam int BIT_W = 3;
    localparam int IO_ADDR_W = 5;

    // status flag positions inside the core status register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // reset values and program counter width limits
    localparam logic [CORE_STATUS_REGISTER_W-1:0] CORE_STATUS_REGISTER_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam int PC_W_MIN = 8;
    localparam int PC_W_MAX = 22;

    // operations handled here; named flag branches map onto the generic pair
    typedef enum logic [3:0] {
        BBF_OP_NOP = 4'h0,
        BBF_OP_BR_SET = 4'h1,
        BBF_OP_BR_CLR = 4'h2,
        BBF_OP_BR_SGE = 4'h3,
        BBF_OP_BR_SLT = 4'h4,
        BBF_OP_IO_SET = 4'h5,
        BBF_OP_IO_CLR = 4'h6,
        BBF_OP_ROL = 4'h7,
        BBF_OP_ROR = 4'h8,
        BBF_OP_BST = 4'h9,
        BBF_OP_BLD = 4'hA,
        BBF_OP_FLAG_SET = 4'hB,
        BBF_OP_FLAG_CLR = 4'hC
    } bbf_op_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        BBF_ST_IDLE = 3'b001,
        BBF_ST_BRANCH2 = 3'b010,
        BBF_ST_IO_RMW = 3'b100
    } bbf_state_t;

    // true for every conditional relative branch
    function automatic logic bbf_is_branch(input bbf_op_t op);
        bbf_is_branch = (op == BBF_OP_BR_SET) || (op == BBF_OP_BR_CLR) ||
                        (op == BBF_OP_BR_SGE) || (op == BBF_OP_BR_SLT);
    endfunction

endpackage

//--- core/bbf_branch_cond.sv
// Purpose: evaluates the condition of a conditional relative branch
// Assumes: status register value is the one before the branch executes
// Notes: purely combinational, reads flags and never writes them

`timescale 1ns/1ps
`default_nettype none

module bbf_branch_cond
    import bbf_pkg::*;
(
    input wire logic [bbf_pkg::CORE_STATUS_REGISTER_W-1:0] core_status_register,
    input wire bbf_pkg::bbf_op_t op,
    input wire logic [bbf_pkg::BIT_W-1:0] flag_sel,
    output logic taken
);

    logic signed_lt;

    // signed compare result from negative and overflow
    assign signed_lt = core_status_register[FLAG_N] ^ core_status_register[FLAG_V];

    // pick the tested flag and polarity
    always_comb begin
        taken = 1'b0;
        case (op)
            BBF_OP_BR_SET: taken = core_status_register[flag_sel];
            BBF_OP_BR_CLR: taken = ~core_status_register[flag_sel];
            BBF_OP_BR_SGE: taken = ~signed_lt;
            BBF_OP_BR_SLT: taken = signed_lt;
            default: taken = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

//--- core/bbf_pc_target.sv
// Purpose: sequential and relative-branch program counter values
// Assumes: offset is a signed two's-complement word count
// Notes: addition wraps at the program counter width

`timescale 1ns/1ps
`default_nettype none

module bbf_pc_target
    import bbf_pkg::*;
#(
    parameter int PC_W = 16
) (
    input wire logic [PC_W-1:0] pc,
    input wire logic [bbf_pkg::OFF_W-1:0] offset,
    output logic [PC_W-1:0] pc_seq,
    output logic [PC_W-1:0] pc_branch
);

    logic [PC_W-1:0] offset_ext;

    // the sign extension needs at least one bit above the offset
    generate
        if (PC_W <= OFF_W) begin : g_bad_pc_w
            $error("bbf_pc_target: PC_W must exceed OFF_W");
        end
    endgenerate

    // sign extension lets backward targets wrap correctly
    assign offset_ext = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset};
    assign pc_seq = pc + {{(PC_W-1){1'b0}}, 1'b1};
    assign pc_branch = pc_seq + offset_ext;

endmodule

`default_nettype wire

//--- core/bbf_unit.sv
// Purpose: executes flag branches, I/O bit set/clear, rotates through
//          carry, transfer-flag bit moves and single flag set/clear
// Assumes: register file and I/O space answer reads in the same cycle
// Notes: owns program counter and status register of the core

`timescale 1ns/1ps
`default_nettype none

module bbf_unit
    import bbf_pkg::*;
#(
    parameter int PC_W = 16,
    parameter logic [PC_W-1:0] PC_RST = '0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire bbf_pkg::bbf_op_t INSTR_OP,
    input wire logic [bbf_pkg::OFF_W-1:0] OFFSET_K,
    input wire logic [bbf_pkg::BIT_W-1:0] BIT_SEL,
    input wire logic [bbf_pkg::BIT_W-1:0] FLAG_SEL,
    input wire logic [bbf_pkg::IO_ADDR_W-1:0] IO_ADDR,
    input wire logic [bbf_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic [bbf_pkg::DATA_W-1:0] IO_RDATA,
    output logic READY,
    output logic [PC_W-1:0] PC,
    output logic [bbf_pkg::CORE_STATUS_REGISTER_W-1:0] STATUS,
    output logic REG_WE,
    output logic [bbf_pkg::DATA_W-1:0] REG_WDATA,
    output logic [bbf_pkg::IO_ADDR_W-1:0] IO_RD_ADDR,
    output logic IO_WE,
    output logic [bbf_pkg::IO_ADDR_W-1:0] IO_WADDR,
    output logic [bbf_pkg::DATA_W-1:0] IO_WDATA
);

    // refuse widths the sign extension and adder cannot serve
    generate
        if (PC_W < PC_W_MIN || PC_W > PC_W_MAX) begin : g_bad_pc_w
            $error("bbf_unit: PC_W out of range");
        end
    endgenerate

    typedef struct packed {
        bbf_state_t state;
        logic [PC_W-1:0] pc;
        logic [CORE_STATUS_REGISTER_W-1:0] core_status_register;
        logic [IO_ADDR_W-1:0] io_addr;
        logic [BIT_W-1:0] io_bit;
        logic io_val;
        logic io_we;
        logic [DATA_W-1:0] io_wdata;
        logic reg_we;
        logic [DATA_W-1:0] reg_wdata;
    } bbf_regs_t;

    bbf_regs_t st_r;
    bbf_regs_t st_nxt;

    logic accept;
    logic br_taken;
    logic [PC_W-1:0] pc_seq;
    logic [PC_W-1:0] pc_branch;

    // a new instruction is only taken while nothing is in flight
    assign READY = (st_r.state == BBF_ST_IDLE);
    assign accept = INSTR_VALID && READY;

    bbf_branch_cond u_cond (
        .core_status_register(st_r.core_status_register),
        .op(INSTR_OP),
        .flag_sel(FLAG_SEL),
        .taken(br_taken)
    );

    bbf_pc_target #(.PC_W(PC_W)) u_target (
        .pc(st_r.pc),
        .offset(OFFSET_K),
        .pc_seq(pc_seq),
        .pc_branch(pc_branch)
    );

    // read address stays put for the whole read-modify-write
    assign IO_RD_ADDR = st_r.io_addr;

    // next-state logic for every register of the unit
    always_comb begin
        logic [DATA_W-1:0] rot;
        logic rot_c;
        logic [DATA_W-1:0] rmw;
        rot = DATA_ZERO;
        rot_c = 1'b0;
        rmw = IO_RDATA;
        st_nxt = st_r;
        st_nxt.io_we = 1'b0;
        st_nxt.reg_we = 1'b0;
        case (st_r.state)
            BBF_ST_IDLE: begin
                if (accept) begin
                    st_nxt.pc = pc_seq;
                    case (INSTR_OP)
                        // taken branches load target, take a second cycle
                        BBF_OP_BR_SET, BBF_OP_BR_CLR,
                        BBF_OP_BR_SGE, BBF_OP_BR_SLT: begin
                            if (br_taken) begin
                                st_nxt.pc = pc_branch;
                                st_nxt.state = BBF_ST_BRANCH2;
                            end
                        end
                        // capture target bit, modify next cycle
                        BBF_OP_IO_SET, BBF_OP_IO_CLR: begin
                            st_nxt.io_addr = IO_ADDR;
                            st_nxt.io_bit = BIT_SEL;
                            st_nxt.io_val = (INSTR_OP == BBF_OP_IO_SET);
                            st_nxt.state = BBF_ST_IO_RMW;
                        end
                        // old carry into bit 0, bit 7 to carry
                        BBF_OP_ROL: begin
                            rot = {REG_RDATA[DATA_W-2:0], st_r.core_status_register[FLAG_C]};
                            rot_c = REG_RDATA[DATA_W-1];
                            st_nxt.reg_we = 1'b1;
                            st_nxt.reg_wdata = rot;
                            st_nxt.core_status_register[FLAG_C] = rot_c;
                            st_nxt.core_status_register[FLAG_Z] = (rot == DATA_ZERO);
                            st_nxt.core_status_register[FLAG_N] = rot[DATA_W-1];
                            st_nxt.core_status_register[FLAG_V] = rot[DATA_W-1] ^ rot_c;
                        end
                        // old carry into bit 7, bit 0 to carry
                        BBF_OP_ROR: begin
                            rot = {st_r.core_status_register[FLAG_C], REG_RDATA[DATA_W-1:1]};
                            rot_c = REG_RDATA[0];
                            st_nxt.reg_we = 1'b1;
                            st_nxt.reg_wdata = rot;
                            st_nxt.core_status_register[FLAG_C] = rot_c;
                            st_nxt.core_status_register[FLAG_Z] = (rot == DATA_ZERO);
                            st_nxt.core_status_register[FLAG_N] = rot[DATA_W-1];
                            st_nxt.core_status_register[FLAG_V] = rot[DATA_W-1] ^ rot_c;
                        end
                        BBF_OP_BST: begin
                            st_nxt.core_status_register[FLAG_T] = REG_RDATA[BIT_SEL];
                        end
                        // transfer flag into one register bit
                        BBF_OP_BLD: begin
                            rot = REG_RDATA;
                            rot[BIT_SEL] = st_r.core_status_register[FLAG_T];
                            st_nxt.reg_we = 1'b1;
                            st_nxt.reg_wdata = rot;
                        end
                        BBF_OP_FLAG_SET: st_nxt.core_status_register[FLAG_SEL] = 1'b1;
                        BBF_OP_FLAG_CLR: st_nxt.core_status_register[FLAG_SEL] = 1'b0;
                        default: st_nxt.pc = pc_seq;
                    endcase
                end
            end
            // second cycle of a taken branch: fetch redirect bubble
            BBF_ST_BRANCH2: st_nxt.state = BBF_ST_IDLE;
            // single-bit change; every other bit is written back as it was read
            BBF_ST_IO_RMW: begin
                rmw[st_r.io_bit] = st_r.io_val;
                st_nxt.io_we = 1'b1;
                st_nxt.io_wdata = rmw;
                st_nxt.state = BBF_ST_IDLE;
            end
            default: st_nxt.state = BBF_ST_IDLE;
        endcase
    end

    // state register, synchronous reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r.state <= BBF_ST_IDLE;
            st_r.pc <= PC_RST;
            st_r.core_status_register <= CORE_STATUS_REGISTER_RST;
            st_r.io_addr <= '0;
            st_r.io_bit <= '0;
            st_r.io_val <= 1'b0;
            st_r.io_we <= 1'b0;
            st_r.io_wdata <= DATA_ZERO;
            st_r.reg_we <= 1'b0;
            st_r.reg_wdata <= DATA_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign PC = st_r.pc;
    assign STATUS = st_r.core_status_register;
    assign REG_WE = st_r.reg_we;
    assign REG_WDATA = st_r.reg_wdata;
    assign IO_WE = st_r.io_we;
    assign IO_WADDR = st_r.io_addr;
    assign IO_WDATA = st_r.io_wdata;

    // checks on the unit's own behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    carry_branch_a: assert property (
        accept && INSTR_OP == BBF_OP_BR_CLR && FLAG_SEL == FLAG_C
        && !STATUS[FLAG_C]
        |=> PC == $past(pc_branch) && !READY ##1 READY)
        else $error("carry-clear branch target or timing wrong");

    signed_branch_a: assert property (
        accept && (INSTR_OP == BBF_OP_BR_SGE || INSTR_OP == BBF_OP_BR_SLT)
        |=> PC == (($past(STATUS[FLAG_N] ^ STATUS[FLAG_V])
                    == ($past(INSTR_OP) == BBF_OP_BR_SLT))
                   ? $past(pc_branch) : $past(pc_seq)))
        else $error("signed branch decision wrong");

    branch_flags_a: assert property (
        accept && bbf_is_branch(INSTR_OP)
        |=> $stable(STATUS) ##1 ($past(READY) || $stable(STATUS)))
        else $error("branch changed a status flag");

    fallthru_pc_a: assert property (
        accept && bbf_is_branch(INSTR_OP) && !br_taken
        |=> PC == $past(pc_seq) && READY)
        else $error("untaken branch did not fall through in one cycle");

    io_bit_a: assert property (
        accept && (INSTR_OP == BBF_OP_IO_SET || INSTR_OP == BBF_OP_IO_CLR)
        |=> !READY ##1 IO_WE && READY
            && IO_WDATA[$past(BIT_SEL, 2)]
               == ($past(INSTR_OP, 2) == BBF_OP_IO_SET)
            && IO_WADDR == $past(IO_ADDR, 2)
            && STATUS == $past(STATUS, 2))
        else $error("io bit set or clear wrong");

    rotate_left_a: assert property (
        accept && INSTR_OP == BBF_OP_ROL
        |=> REG_WE && REG_WDATA == {$past(REG_RDATA[6:0]),
                                    $past(STATUS[FLAG_C])}
            && STATUS[FLAG_C] == $past(REG_RDATA[7]) && READY)
        else $error("rotate left result or carry wrong");

    rotate_right_a: assert property (
        accept && INSTR_OP == BBF_OP_ROR
        |=> REG_WE && REG_WDATA == {$past(STATUS[FLAG_C]),
                                    $past(REG_RDATA[7:1])}
            && STATUS[FLAG_C] == $past(REG_RDATA[0])
            && STATUS[FLAG_V] == (STATUS[FLAG_N] ^ STATUS[FLAG_C]))
        else $error("rotate right result or flags wrong");

    bit_store_a: assert property (
        accept && INSTR_OP == BBF_OP_BST
        |=> STATUS[FLAG_T] == $past(REG_RDATA[BIT_SEL]) && !REG_WE
            && (STATUS | 8'h40) == ($past(STATUS) | 8'h40))
        else $error("bit store to transfer flag wrong");

    bit_load_a: assert property (
        accept && INSTR_OP == BBF_OP_BLD
        |=> REG_WE && REG_WDATA[$past(BIT_SEL)] == $past(STATUS[FLAG_T])
            && STATUS == $past(STATUS))
        else $error("bit load from transfer flag wrong");

    flag_write_a: assert property (
        accept && (INSTR_OP == BBF_OP_FLAG_SET
                   || INSTR_OP == BBF_OP_FLAG_CLR)
        |=> STATUS[$past(FLAG_SEL)]
                == ($past(INSTR_OP) == BBF_OP_FLAG_SET)
            && (STATUS ^ $past(STATUS))
               == (8'h01 << $past(FLAG_SEL) & (STATUS ^ $past(STATUS)))
            && READY)
        else $error("flag set or clear touched the wrong bits");

    halfcarry_branch_a: assert property (
        accept && INSTR_OP == BBF_OP_BR_SET && FLAG_SEL == FLAG_H
        |=> PC == ($past(STATUS[FLAG_H]) ? $past(pc_branch)
                                          : $past(pc_seq)))
        else $error("half-carry branch decision wrong");

    transfer_branch_a: assert property (
        accept && INSTR_OP == BBF_OP_BR_CLR && FLAG_SEL == FLAG_T
        |=> PC == ($past(STATUS[FLAG_T]) ? $past(pc_seq)
                                          : $past(pc_branch)))
        else $error("transfer-flag branch decision wrong");

    overflow_branch_a: assert property (
        accept && INSTR_OP == BBF_OP_BR_SET && FLAG_SEL == FLAG_V
        |=> PC == ($past(STATUS[FLAG_V]) ? $past(pc_branch)
                                          : $past(pc_seq)))
        else $error("overflow branch decision wrong");

    branch_offset_a: assert property (
        accept && bbf_is_branch(INSTR_OP) && br_taken
        |=> PC == $past(PC) + {{(PC_W-1){1'b0}}, 1'b1}
                 + {{(PC_W-OFF_W){$past(OFFSET_K[OFF_W-1])}},
                    $past(OFFSET_K)})
        else $error("taken branch target not next pc plus signed k");

    sign_overflow_a: assert property (
        accept && (INSTR_OP == BBF_OP_FLAG_SET
                   || INSTR_OP == BBF_OP_FLAG_CLR)
        && (FLAG_SEL == FLAG_S || FLAG_SEL == FLAG_V)
        |=> (STATUS & ~(8'h01 << $past(FLAG_SEL)))
            == ($past(STATUS) & ~(8'h01 << $past(FLAG_SEL))))
        else $error("sign or overflow instruction touched other flags");

endmodule

`default_nettype wire

//--- bench/branch_bit_flag_instr_unit_bench.sv
// Purpose: self-checking bench for the branch, bit and flag unit
// Assumes: bench drives every port itself, no far-side model needed
// Notes: a reference of PC and status is kept here, fed by random ops

`timescale 1ns/1ps
`default_nettype none

module branch_bit_flag_instr_unit_bench;
    import bbf_pkg::*;

    localparam int PC_W = 16;

    logic CLK;
    logic RST;
    logic INSTR_VALID;
    bbf_op_t INSTR_OP;
    logic [OFF_W-1:0] OFFSET_K;
    logic [BIT_W-1:0] BIT_SEL;
    logic [BIT_W-1:0] FLAG_SEL;
    logic [IO_ADDR_W-1:0] IO_ADDR;
    logic [DATA_W-1:0] REG_RDATA;
    logic [DATA_W-1:0] IO_RDATA;
    logic READY;
    logic [PC_W-1:0] PC;
    logic [CORE_STATUS_REGISTER_W-1:0] STATUS;
    logic REG_WE;
    logic [DATA_W-1:0] REG_WDATA;
    logic [IO_ADDR_W-1:0] IO_RD_ADDR;
    logic IO_WE;
    logic [IO_ADDR_W-1:0] IO_WADDR;
    logic [DATA_W-1:0] IO_WDATA;
    int n_errors;
    int n_tests;
    int seed;
    int i;
    logic [PC_W-1:0] pc_m;
    logic [CORE_STATUS_REGISTER_W-1:0] sr_m;

    bbf_unit #(.PC_W(PC_W), .PC_RST(16'h0000)) dut_u (
        .CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
        .INSTR_OP(INSTR_OP), .OFFSET_K(OFFSET_K), .BIT_SEL(BIT_SEL),
        .FLAG_SEL(FLAG_SEL), .IO_ADDR(IO_ADDR), .REG_RDATA(REG_RDATA),
        .IO_RDATA(IO_RDATA), .READY(READY), .PC(PC), .STATUS(STATUS),
        .REG_WE(REG_WE), .REG_WDATA(REG_WDATA), .IO_RD_ADDR(IO_RD_ADDR),
        .IO_WE(IO_WE), .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA)
    );

    // 40 MHz core clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // branch decision from the flags as they stood before the branch
    function automatic logic br_exp(input bbf_op_t op, input logic [2:0] f,
                                    input logic [7:0] s);
        case (op)
            BBF_OP_BR_SET: return s[f];
            BBF_OP_BR_CLR: return !s[f];
            BBF_OP_BR_SGE: return !(s[FLAG_N] ^ s[FLAG_V]);
            BBF_OP_BR_SLT: return s[FLAG_N] ^ s[FLAG_V];
            default: return 1'b0;
        endcase
    endfunction

    // one instruction: issue in c0, check c1, check c2; valid is dropped
    // in c1 so the next issue never lands in the same time step
    task automatic run_op(input bbf_op_t op, input logic [6:0] k,
        input logic [2:0] b, input logic [2:0] f, input logic [4:0] a,
        input logic [7:0] rd, input logic [7:0] iod);
        logic tk;
        logic io;
        logic rwe;
        logic [7:0] res;
        logic [7:0] sr0;
        logic [7:0] iow;
        sr0 = sr_m;
        tk = br_exp(op, f, sr0);
        io = (op == BBF_OP_IO_SET) || (op == BBF_OP_IO_CLR);
        rwe = (op == BBF_OP_ROL) || (op == BBF_OP_ROR) || (op == BBF_OP_BLD);
        res = rd;
        iow = (op == BBF_OP_IO_SET) ? (iod | (8'h01 << b))
                                    : (iod & ~(8'h01 << b));
        INSTR_VALID = 1'b1;
        INSTR_OP = op;
        OFFSET_K = k;
        BIT_SEL = b;
        FLAG_SEL = f;
        IO_ADDR = a;
        REG_RDATA = rd;
        IO_RDATA = iod;
        @(posedge CLK);
        #2;
        INSTR_VALID = 1'b0;
        // offset is sign-extended, so backward targets wrap correctly
        pc_m = tk ? pc_m + 16'h0001 + {{9{k[6]}}, k} : pc_m + 16'h0001;
        case (op)
            BBF_OP_ROL: res = {rd[6:0], sr0[FLAG_C]};
            BBF_OP_ROR: res = {sr0[FLAG_C], rd[7:1]};
            BBF_OP_BST: sr_m[FLAG_T] = rd[b];
            BBF_OP_BLD: res[b] = sr0[FLAG_T];
            BBF_OP_FLAG_SET: sr_m[f] = 1'b1;
            BBF_OP_FLAG_CLR: sr_m[f] = 1'b0;
            default: ;
        endcase
        if (op == BBF_OP_ROL || op == BBF_OP_ROR) begin
            sr_m[FLAG_C] = (op == BBF_OP_ROL) ? rd[7] : rd[0];
            sr_m[FLAG_Z] = (res == 8'h00);
            sr_m[FLAG_N] = res[7];
            sr_m[FLAG_V] = res[7] ^ sr_m[FLAG_C];
        end
        if (op == BBF_OP_BR_SGE || op == BBF_OP_BR_SLT)
            check("signed pc", PC, pc_m);
        else if (op == BBF_OP_BR_SET || op == BBF_OP_BR_CLR) begin
            case (f)
                FLAG_C: check("carry pc", PC, pc_m);
                FLAG_H: check("half pc", PC, pc_m);
                FLAG_T: check("transfer pc", PC, pc_m);
                FLAG_V: check("overflow pc", PC, pc_m);
                FLAG_I: check("irq pc", PC, pc_m);
                default: check("flag pc", PC, pc_m);
            endcase
        end else
            check("next pc", PC, pc_m);
        check("ready", 16'(READY), 16'(!(tk || io)));
        check("reg we", 16'(REG_WE), 16'(rwe));
        case (op)
            BBF_OP_ROL: check("rol data", 16'(REG_WDATA), 16'(res));
            BBF_OP_ROR: check("ror data", 16'(REG_WDATA), 16'(res));
            BBF_OP_BLD: check("bld data", 16'(REG_WDATA), 16'(res));
            BBF_OP_BST: check("bst flags", 16'(STATUS), 16'(sr_m));
            BBF_OP_FLAG_SET, BBF_OP_FLAG_CLR:
                check("flag op", 16'(STATUS), 16'(sr_m));
            default: ;
        endcase
        check("status", 16'(STATUS), 16'(sr_m));
        if ((op == BBF_OP_FLAG_SET || op == BBF_OP_FLAG_CLR) &&
            (f == FLAG_S || f == FLAG_V))
            check("others", 16'(STATUS & ~(8'h01 << f)),
                  16'(sr0 & ~(8'h01 << f)));
        if (io)
            check("io raddr", 16'(IO_RD_ADDR), 16'(a));
        @(posedge CLK);
        #2;
        check("io we", 16'(IO_WE), 16'(io));
        if (io) begin
            check("io waddr", 16'(IO_WADDR), 16'(a));
            check("io wdata", 16'(IO_WDATA), 16'(iow));
        end
        check("ready again", 16'(READY), 16'h0001);
        check("pc hold", PC, pc_m);
    endtask

    // random instruction with every field drawn from the fixed seed
    task automatic rand_op();
        bbf_op_t op;
        op = bbf_op_t'(4'(($random(seed) & 32'h7FFF_FFFF) % 13));
        run_op(op, 7'($random(seed)), 3'($random(seed)),
               3'($random(seed)), 5'($random(seed)), 8'($random(seed)),
               8'($random(seed)));
    endtask

    // cuts a hang short
    initial begin
        #500000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        seed = 91242;
        n_errors = 0;
        n_tests = 0;
        RST = 1'b1;
        INSTR_VALID = 1'b0;
        INSTR_OP = BBF_OP_NOP;
        OFFSET_K = 7'h00;
        BIT_SEL = 3'h0;
        FLAG_SEL = 3'h0;
        IO_ADDR = 5'h00;
        REG_RDATA = 8'h00;
        IO_RDATA = 8'h00;
        pc_m = 16'h0000;
        sr_m = CORE_STATUS_REGISTER_RST;
        repeat (3) @(posedge CLK);
        #2;
        RST = 1'b0;
        check("reset pc", PC, 16'h0000);
        check("reset status", 16'(STATUS), 16'(CORE_STATUS_REGISTER_RST));
        // each flag set and cleared, branched on both ways, extreme offsets
        for (i = 0; i < 8; i++) begin
            run_op(BBF_OP_FLAG_SET, 7'h00, 3'h0, 3'(i), 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_BR_SET, 7'h3F, 3'h0, 3'(i), 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_BR_CLR, 7'h05, 3'h0, 3'(i), 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_FLAG_CLR, 7'h00, 3'h0, 3'(i), 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_BR_CLR, 7'h40, 3'h0, 3'(i), 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_BR_SET, 7'h7F, 3'h0, 3'(i), 5'h00, 8'h00, 8'h00);
        end
        // all four negative and overflow pairings for the signed branches
        for (i = 0; i < 4; i++) begin
            run_op(i[0] ? BBF_OP_FLAG_SET : BBF_OP_FLAG_CLR, 7'h00, 3'h0,
                   3'(FLAG_N), 5'h00, 8'h00, 8'h00);
            run_op(i[1] ? BBF_OP_FLAG_SET : BBF_OP_FLAG_CLR, 7'h00, 3'h0,
                   3'(FLAG_V), 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_BR_SGE, 7'h7E, 3'h0, 3'h0, 5'h00, 8'h00, 8'h00);
            run_op(BBF_OP_BR_SLT, 7'h02, 3'h0, 3'h0, 5'h00, 8'h00, 8'h00);
        end
        // rotate left to zero with carry out, rotate right with that carry in, then io at both address ends
        run_op(BBF_OP_FLAG_CLR, 7'h00, 3'h0, 3'(FLAG_C), 5'h00, 8'h00, 8'h00);
        run_op(BBF_OP_ROL, 7'h00, 3'h0, 3'h0, 5'h00, 8'h80, 8'h00);
        run_op(BBF_OP_ROR, 7'h00, 3'h0, 3'h0, 5'h00, 8'h01, 8'h00);
        run_op(BBF_OP_IO_SET, 7'h00, 3'h7, 3'h0, 5'h1F, 8'h00, 8'h00);
        run_op(BBF_OP_IO_CLR, 7'h00, 3'h0, 3'h0, 5'h00, 8'h00, 8'hFF);
        for (i = 0; i < 400; i++)
            rand_op();
        // reset again in mid-run
        RST = 1'b1;
        @(posedge CLK);
        #2;
        RST = 1'b0;
        pc_m = 16'h0000;
        sr_m = CORE_STATUS_REGISTER_RST;
        check("rerun pc", PC, pc_m);
        check("rerun status", 16'(STATUS), 16'(sr_m));
        for (i = 0; i < 100; i++)
            rand_op();
        report_and_stop();
    end

endmodule

`default_nettype wire
